// ==== rtc_clock.sv ====
// Calendar clock behind an asynchronous byte-wide memory port, with coherent-read
// freeze, load freeze, oscillator halt and periodic counter correction.
// Assumes clk runs freely at CLK_HZ (20 MHz by default) and the memory pins are asynchronous.
`timescale 1ns/1ns
`include "rtc_defs.svh"

module rtc_clock
  import rtc_pkg::*;
#(
  parameter int unsigned CLK_HZ = `RTC_CLK_HZ,
  parameter int unsigned REC_CYC = `RTC_REC_MIN_MS * (CLK_HZ / `RTC_MS_PER_S),
  parameter int unsigned START_CYC = `RTC_START_DLY_MS * (CLK_HZ / `RTC_MS_PER_S)
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Asynchronous memory port.
  input wire logic [16:0] mem_addr,
  input wire logic mem_ce_n,
  input wire logic mem_we_n,
  input wire logic mem_oe_n,
  // Data bus, split into input, output and output enable.
  input wire logic [7:0] mem_data_in,
  output logic [7:0] mem_data_out,
  output logic mem_data_oe
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------

  // Increment of a two-digit packed decimal value, no wrap.
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == `RTC_BCD_NINE) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  // Last date of a month; a year is leap when its two digits divide by four.
  function automatic logic [7:0] last_date(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    unique case (mon)
      8'h04, 8'h06, 8'h09, 8'h11: return `RTC_DIM_30;
      8'h02: return leap ? `RTC_DIM_29 : `RTC_DIM_28;
      default: return `RTC_DIM_31;
    endcase
  endfunction : last_date

  // Bits a time register can hold; reserved bits always read as zero.
  function automatic logic [7:0] reg_mask(input logic [2:0] idx);
    unique case (idx)
      `RTC_I_SEC, `RTC_I_MIN: return `RTC_MASK_SEC;
      `RTC_I_HR, `RTC_I_DATE: return `RTC_MASK_HR;
      `RTC_I_DAY: return `RTC_MASK_DAY;
      `RTC_I_MON: return `RTC_MASK_MON;
      default: return `RTC_MASK_ALL;
    endcase
  endfunction : reg_mask

  // ---------------------------------------------------------------------------
  // State and decoded terms
  // ---------------------------------------------------------------------------
  rtc_state_t s;
  rtc_state_t next_s;
  logic hit;
  logic is_ctrl;
  logic is_sec;
  logic [2:0] vidx;
  logic wr_evt;
  logic freeze;
  logic load;
  logic osc_run;
  logic [25:0] acc_sum;
  logic tick;
  logic adj;
  logic [15:0] lim;
  logic sec_end;

  // Address decode on the synchronised pins; only the top eight bytes are ours.
  assign hit = (s.a_s2[16:13] == `RTC_ADDR_TOP) && ({s.a_s2[12:3], 3'h0} == `RTC_OFS_CTRL);
  assign is_ctrl = (s.a_s2[12:0] == `RTC_OFS_CTRL);
  assign is_sec = (s.a_s2[12:0] == `RTC_OFS_SEC);
  assign vidx = 3'(s.a_s2[12:0] - `RTC_OFS_SEC);

  // A write lands on the rising edge of write enable while chip enable was low.
  assign wr_evt = s.rec_done && hit && !s.c_d[`RTC_PIN_WE] && s.c_s2[`RTC_PIN_WE]
                  && !s.c_d[`RTC_PIN_CE];

  // Either freeze bit suspends refreshing; the commit runs one cycle after release.
  assign freeze = s.ctrl[`RTC_BIT_WRITE] || s.ctrl[`RTC_BIT_READ];
  assign load = s.prev_w && !s.ctrl[`RTC_BIT_WRITE];

  // The 32768 Hz time base is a fractional accumulator on the system clock.
  // The accumulator is 25 bits wide, so CLK_HZ must stay below about 33 MHz.
  assign osc_run = !s.osc_halt && (s.start_cnt == '0);
  assign acc_sum = {1'b0, s.acc} + 26'(`RTC_OSC_HZ);
  assign tick = osc_run && (acc_sum >= 26'(CLK_HZ));

  // The first second of each early minute in the 64-minute cycle is adjusted.
  assign adj = (s.cnt[`RTC_I_SEC] == `RTC_RST_ZERO) && (s.cyc_min < `RTC_CAL_ELIG_MIN)
               && (s.cyc_min < {s.ctrl[`RTC_CAL_MSB:0], 1'b0});
  assign lim = !adj ? `RTC_SEC_LAST
             : s.ctrl[`RTC_BIT_SIGN] ? (`RTC_SEC_LAST - `RTC_CAL_POS_CYC)
             : (`RTC_SEC_LAST + `RTC_CAL_NEG_CYC);
  assign sec_end = tick && (s.sub == lim);

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------

  // Every register of the block is computed here and stored by one flop process.
  always_comb begin
    next_s = s;
    // Two flops on each pin; the edge detect looks only at the second and later.
    next_s.a_s1 = mem_addr;
    next_s.a_s2 = s.a_s1;
    next_s.d_s1 = mem_data_in;
    next_s.d_s2 = s.d_s1;
    next_s.d_d = s.d_s2;
    next_s.c_s1 = {mem_ce_n, mem_we_n, mem_oe_n};
    next_s.c_s2 = s.c_s1;
    next_s.c_d = s.c_s2;

    // The bus stays deaf after power-up; the minimum keeps margin below the maximum.
    if (!s.rec_done) begin
      if (s.rec_cnt == 24'(REC_CYC - 1)) begin
        next_s.rec_done = 1'b1;
      end else begin
        next_s.rec_cnt = s.rec_cnt + 24'h1;
      end
    end

    // Oscillator start delay runs out before the time base moves again.
    if (s.start_cnt != '0) begin
      next_s.start_cnt = s.start_cnt - 25'h1;
    end

    // Time base accumulator.
    if (osc_run) begin
      next_s.acc = tick ? 25'(acc_sum - 26'(CLK_HZ)) : acc_sum[24:0];
    end

    // Counters: the commit wins over any advance in the same cycle.
    next_s.prev_w = s.ctrl[`RTC_BIT_WRITE];
    if (load) begin
      next_s.cnt = s.vis;
      next_s.sub = '0;
    end else if (tick) begin
      if (sec_end) begin
        next_s.sub = '0;
        next_s.cnt[`RTC_I_SEC] = bcd_inc(s.cnt[`RTC_I_SEC]);
        if (s.cnt[`RTC_I_SEC] == `RTC_MAX_SEC) begin
          next_s.cnt[`RTC_I_SEC] = `RTC_RST_ZERO;
          next_s.cnt[`RTC_I_MIN] = bcd_inc(s.cnt[`RTC_I_MIN]);
          next_s.cyc_min = s.cyc_min + 6'h01;
          if (s.cnt[`RTC_I_MIN] == `RTC_MAX_SEC) begin
            next_s.cnt[`RTC_I_MIN] = `RTC_RST_ZERO;
            next_s.cnt[`RTC_I_HR] = bcd_inc(s.cnt[`RTC_I_HR]);
            if (s.cnt[`RTC_I_HR] == `RTC_MAX_HR) begin
              next_s.cnt[`RTC_I_HR] = `RTC_RST_ZERO;
              next_s.cnt[`RTC_I_DAY] = bcd_inc(s.cnt[`RTC_I_DAY]);
              next_s.cnt[`RTC_I_DATE] = bcd_inc(s.cnt[`RTC_I_DATE]);
              if (s.cnt[`RTC_I_DAY] == `RTC_MAX_DAY) begin
                next_s.cnt[`RTC_I_DAY] = `RTC_RST_ONE;
              end
              if (s.cnt[`RTC_I_DATE] == last_date(s.cnt[`RTC_I_MON], s.cnt[`RTC_I_YR])) begin
                next_s.cnt[`RTC_I_DATE] = `RTC_RST_ONE;
                next_s.cnt[`RTC_I_MON] = bcd_inc(s.cnt[`RTC_I_MON]);
                if (s.cnt[`RTC_I_MON] == `RTC_MAX_MON) begin
                  next_s.cnt[`RTC_I_MON] = `RTC_RST_ONE;
                  next_s.cnt[`RTC_I_YR] = bcd_inc(s.cnt[`RTC_I_YR]);
                  if (s.cnt[`RTC_I_YR] == `RTC_MAX_YR) begin
                    next_s.cnt[`RTC_I_YR] = `RTC_RST_ZERO;
                  end
                end
              end
            end
          end
        end
      end else begin
        next_s.sub = s.sub + 16'h0001;
      end
    end

    // Whole-copy refresh in one cycle; a freeze held in ctrl now blocks it in this same cycle.
    if (!freeze && !load) begin
      next_s.vis = s.cnt;
    end

    // Host writes; time registers take data only while a freeze holds them.
    if (wr_evt) begin
      if (is_ctrl) begin
        next_s.ctrl = s.d_d;
      end else begin
        if (is_sec) begin
          next_s.osc_halt = s.d_d[`RTC_BIT_HALT];
          if (s.osc_halt && !s.d_d[`RTC_BIT_HALT]) begin
            next_s.start_cnt = 25'(START_CYC);
          end else if (s.d_d[`RTC_BIT_HALT]) begin
            next_s.start_cnt = '0;
          end
        end
        if (freeze) begin
          next_s.vis[vidx] = s.d_d & reg_mask(vidx);
        end
      end
    end

    // Read path: driven only while chip and output enable are low and write is high.
    next_s.doe = s.rec_done && hit && !s.c_s2[`RTC_PIN_CE] && !s.c_s2[`RTC_PIN_OE]
                 && s.c_s2[`RTC_PIN_WE];
    if (is_ctrl) begin
      next_s.dout = s.ctrl;
    end else if (is_sec) begin
      next_s.dout = {s.osc_halt, s.vis[`RTC_I_SEC][6:0]};
    end else begin
      next_s.dout = s.vis[vidx];
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------

  // Synchronous reset; the oscillator comes up halted so time is never trusted blind.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
      s.osc_halt <= `RTC_RST_HALT;
      // Pin history starts at the idle level, so no false write edge follows reset.
      s.c_s1 <= '1;
      s.c_s2 <= '1;
      s.c_d <= '1;
      s.cnt[`RTC_I_DAY] <= `RTC_RST_ONE;
      s.cnt[`RTC_I_DATE] <= `RTC_RST_ONE;
      s.cnt[`RTC_I_MON] <= `RTC_RST_ONE;
      s.vis[`RTC_I_DAY] <= `RTC_RST_ONE;
      s.vis[`RTC_I_DATE] <= `RTC_RST_ONE;
      s.vis[`RTC_I_MON] <= `RTC_RST_ONE;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state flops.
  assign mem_data_out = s.dout;
  assign mem_data_oe = s.doe;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------

  // A held read freeze keeps the visible registers still except for host writes.
  chk_read_freeze_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    (s.ctrl[`RTC_BIT_READ] && !wr_evt) |=> $stable(s.vis))
    else $error("visible time changed during read freeze");

  // A held write freeze changes visible registers only by host writes.
  chk_write_freeze_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    (s.ctrl[`RTC_BIT_WRITE] && !wr_evt) |=> $stable(s.vis))
    else $error("visible time changed during write freeze");

  // Unfrozen, every visible register copies the counters in the same cycle.
  chk_refresh_whole: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!freeze && !load) |=> (s.vis == $past(s.cnt)))
    else $error("visible registers not refreshed together");

  // Releasing the read freeze refreshes on the next edge.
  chk_resume_refresh: assert property (
    @(posedge clk) disable iff (sys_rst)
    ($fell(s.ctrl[`RTC_BIT_READ]) && !s.ctrl[`RTC_BIT_WRITE] && !load)
      |=> (s.vis == $past(s.cnt)))
    else $error("refresh did not resume after read freeze");

  // The commit copies the loaded values and restarts the second.
  chk_write_commit: assert property (
    @(posedge clk) disable iff (sys_rst)
    load |=> (s.cnt == $past(s.vis)) && (s.sub == '0))
    else $error("write freeze release did not commit");

  // A halted oscillator moves neither the second divider nor the time base.
  chk_halt_stops: assert property (
    @(posedge clk) disable iff (sys_rst)
    (s.osc_halt && !load) [*2] |-> $stable(s.sub) && $stable(s.acc))
    else $error("time moved while halted");

  // Clearing the halt arms the full start delay before any tick.
  chk_start_delay: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(s.osc_halt) |-> (s.start_cnt == 25'(START_CYC)) && !tick)
    else $error("oscillator restarted without delay");

  // Adjusted seconds fall only in the eligible early minutes.
  chk_cal_window: assert property (
    @(posedge clk) disable iff (sys_rst)
    (sec_end && lim != `RTC_SEC_LAST)
      |-> (s.cyc_min < `RTC_CAL_ELIG_MIN) && (s.cyc_min < {s.ctrl[`RTC_CAL_MSB:0], 1'b0}))
    else $error("correction outside its minutes");

  // An adjusted second ends exactly 256 cycles early or 128 cycles late.
  chk_cal_length: assert property (
    @(posedge clk) disable iff (sys_rst)
    (sec_end && adj) |-> (s.sub == (s.ctrl[`RTC_BIT_SIGN] ?
      `RTC_SEC_LAST - `RTC_CAL_POS_CYC : `RTC_SEC_LAST + `RTC_CAL_NEG_CYC)))
    else $error("adjusted second has wrong length");

  // During input recovery the data bus is never driven.
  chk_bus_ignored: assert property (
    @(posedge clk) disable iff (sys_rst)
    !s.rec_done |=> !s.doe && !$changed(s.ctrl))
    else $error("bus answered during input recovery");

  // A second advance from a valid hour keeps the hour a valid decimal value.
  chk_bcd_range: assert property (
    @(posedge clk) disable iff (sys_rst)
    (sec_end && !load && (s.cnt[`RTC_I_HR] <= `RTC_MAX_HR)
      && (s.cnt[`RTC_I_HR][3:0] <= `RTC_BCD_NINE))
      |=> (s.cnt[`RTC_I_HR] <= `RTC_MAX_HR) && (s.cnt[`RTC_I_HR][3:0] <= `RTC_BCD_NINE))
    else $error("hours counter left decimal range");

endmodule : rtc_clock

// ==== rtc_clock_tb.sv ====
// Self-checking testbench of the calendar clock, driven through a host model.
// Assumes rtc_pkg, rtc_clock and rtc_host_model are compiled before it.
`timescale 1ns/1ns
`include "rtc_defs.svh"

module rtc_clock_tb;
  // ---------------------------------------------------------------------------
  // Set-up
  // ---------------------------------------------------------------------------
  localparam int unsigned DLY = 2;
  localparam int unsigned REC = 20;
  // Two seconds of one tick per clock plus all bus traffic, with margin.
  localparam int unsigned CYC_LIMIT = 75000;
  logic clk, sys_rst, mem_ce_n, mem_we_n, mem_oe_n, mem_data_oe, host_dq_oe, hit;
  logic [16:0] mem_addr;
  logic [7:0] mem_data_out, host_dq, data_wire, rd;
  logic [7:0] exp_regs [8];
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int i;
  int t0 = 0;

  // Undriven wire shows the inverse of the last host value, never a stale match.
  assign data_wire = host_dq_oe ? host_dq : (mem_data_oe ? mem_data_out : ~host_dq);

  // A system clock rate equal to the oscillator rate makes one second 32768 cycles.
  rtc_clock #(.CLK_HZ(`RTC_OSC_HZ), .REC_CYC(REC), .START_CYC(50)) rtc_clock_inst (
    .clk(clk), .sys_rst(sys_rst), .mem_addr(mem_addr), .mem_ce_n(mem_ce_n),
    .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_data_in(data_wire),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));

  rtc_host_model #(.DLY(DLY)) rtc_host_model_inst (
    .clk(clk), .bus_level(data_wire), .dev_oe(mem_data_oe), .mem_addr(mem_addr),
    .mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n),
    .host_dq(host_dq), .host_dq_oe(host_dq_oe));

  // 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [16:0] reg_addr(input int k);
    return {`RTC_ADDR_TOP, `RTC_OFS_CTRL + 13'(k)};
  endfunction : reg_addr

  task automatic final_report();
    $display("compared %0d, wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : cmp8

  task automatic cmp1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : cmp1

  task automatic wr(input int k, input logic [7:0] d);
    rtc_host_model_inst.bus_write(reg_addr(k), d);
  endtask : wr

  // Waits until n cycles have passed since the mark t0.
  task automatic wait_cyc(input int n);
    while (cyc < t0 + n) begin
      @(posedge clk);
    end
  endtask : wait_cyc

  // Reads all eight registers, control first, against the expected image.
  task automatic check_all();
    for (int k = 0; k < 8; k++) begin
      rtc_host_model_inst.bus_read(reg_addr(k), rd, hit);
      cmp1(hit, 1'b1);
      cmp8(rd, exp_regs[k]);
    end
  endtask : check_all

  task automatic do_reset();
    @(posedge clk);
    #DLY sys_rst = 1'b1;
    repeat (10) @(posedge clk);
    #DLY sys_rst = 1'b0;
    exp_regs = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  endtask : do_reset

  // A hang counts as a mismatch and goes to the closing report.
  always @(posedge clk) begin
    cyc++;
    if (cyc == CYC_LIMIT) begin
      fails++;
      final_report();
    end
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    do_reset();
    // Bus is deaf during recovery, answers once it has run out.
    rtc_host_model_inst.bus_read(reg_addr(0), rd, hit);
    cmp1(hit, 1'b0);
    repeat (REC) @(posedge clk);
    check_all();
    // Unfrozen: time digits are dropped, the halt bit alone is taken.
    wr(2, 8'h45);
    wr(1, 8'h00);
    exp_regs[1] = 8'h00;
    check_all();
    // Every sign and magnitude boundary of the correction field reads back whole.
    for (i = 0; i < 8; i++) begin
      rd = 8'h3F >> i;
      wr(0, {2'b00, (i[0] ? 1'b1 : 1'b0), rd[4:0]});
      rtc_host_model_inst.bus_read(reg_addr(0), rd, hit);
      cmp8(rd, {2'b00, (i[0] ? 1'b1 : 1'b0), 5'(8'h3F >> i)});
    end
    // Load freeze: upper-limit calendar values, then commit on release.
    wr(0, 8'h80);
    exp_regs = '{8'h80, 8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
    for (i = 1; i < 8; i++) begin
      wr(i, exp_regs[i]);
    end
    check_all();
    wr(0, 8'h00);
    exp_regs[0] = 8'h00;
    check_all();
    wr(3, 8'h05);
    check_all();
    // Read freeze with a slow host, then release.
    wr(0, 8'h40);
    exp_regs[0] = 8'h40;
    rtc_host_model_inst.hold_cyc = 9;
    check_all();
    rtc_host_model_inst.hold_cyc = 4;
    wr(0, 8'h00);
    exp_regs[0] = 8'h00;
    check_all();
    // Halt bit set again while running keeps the seconds digits.
    wr(1, 8'h80);
    exp_regs[1] = 8'hD9;
    check_all();
    // Restart, reload the held time and commit it with one step of positive correction.
    wr(1, 8'h59);
    exp_regs[1] = 8'h59;
    check_all();
    wr(0, 8'h80);
    wr(0, 8'h21);
    t0 = cyc;
    wait_cyc(32700);
    rtc_host_model_inst.bus_read(reg_addr(1), rd, hit);
    cmp8(rd, 8'h59);
    wait_cyc(32800);
    exp_regs = '{8'h21, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    check_all();
    // Second 00 of cycle minute 1 is adjusted, so it ends 256 ticks early.
    wait_cyc(65214);
    rtc_host_model_inst.bus_read(reg_addr(1), rd, hit);
    cmp8(rd, 8'h00);
    wait_cyc(65330);
    rtc_host_model_inst.bus_read(reg_addr(1), rd, hit);
    cmp8(rd, 8'h01);
    // Places outside the clock window are never answered.
    rtc_host_model_inst.bus_read(17'h1FFF7, rd, hit);
    cmp1(hit, 1'b0);
    rtc_host_model_inst.bus_read(17'h0FFF8, rd, hit);
    cmp1(hit, 1'b0);
    // Second reset mid-run; a write inside recovery must not land.
    do_reset();
    wr(0, 8'h3F);
    repeat (REC) @(posedge clk);
    check_all();
    final_report();
  end
endmodule : rtc_clock_tb

// ==== rtc_defs.svh ====
// Constants of the calendar clock: timing figures, register offsets, field positions,
// masks and reset values.
// Assumes it is included by its bare name from the package and the clock module.
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define RTC_CLK_HZ 32'h01312D00
`define RTC_OSC_HZ 32'h00008000
`define RTC_MS_PER_S 32'h000003E8
`define RTC_REC_MIN_MS 32'h00000028
`define RTC_REC_MAX_MS 32'h000000C8
`define RTC_START_DLY_MS 32'h000003E8
`define RTC_SEC_LAST 16'h7FFF
`define RTC_CAL_POS_CYC 16'h0100
`define RTC_CAL_NEG_CYC 16'h0080
`define RTC_CAL_ELIG_MIN 6'h3E

// -----------------------------------------------------------------------------
// Address map
// -----------------------------------------------------------------------------
`define RTC_ADDR_TOP 4'hF
`define RTC_OFS_CTRL 13'h1FF8
`define RTC_OFS_SEC 13'h1FF9
`define RTC_OFS_MIN 13'h1FFA
`define RTC_OFS_HR 13'h1FFB
`define RTC_OFS_DAY 13'h1FFC
`define RTC_OFS_DATE 13'h1FFD
`define RTC_OFS_MON 13'h1FFE
`define RTC_OFS_YR 13'h1FFF

// -----------------------------------------------------------------------------
// Fields, indices, limits and reset values
// -----------------------------------------------------------------------------
`define RTC_BIT_WRITE 7
`define RTC_BIT_READ 6
`define RTC_BIT_SIGN 5
`define RTC_BIT_HALT 7
`define RTC_CAL_MSB 4
`define RTC_PIN_CE 2
`define RTC_PIN_WE 1
`define RTC_PIN_OE 0
`define RTC_NUM_TIME 7
`define RTC_I_SEC 3'h0
`define RTC_I_MIN 3'h1
`define RTC_I_HR 3'h2
`define RTC_I_DAY 3'h3
`define RTC_I_DATE 3'h4
`define RTC_I_MON 3'h5
`define RTC_I_YR 3'h6
`define RTC_MASK_SEC 8'h7F
`define RTC_MASK_HR 8'h3F
`define RTC_MASK_DAY 8'h07
`define RTC_MASK_MON 8'h1F
`define RTC_MASK_ALL 8'hFF
`define RTC_MAX_SEC 8'h59
`define RTC_MAX_HR 8'h23
`define RTC_MAX_DAY 8'h07
`define RTC_MAX_MON 8'h12
`define RTC_MAX_YR 8'h99
`define RTC_DIM_31 8'h31
`define RTC_DIM_30 8'h30
`define RTC_DIM_29 8'h29
`define RTC_DIM_28 8'h28
`define RTC_BCD_NINE 4'h9
`define RTC_RST_ZERO 8'h00
`define RTC_RST_ONE 8'h01
`define RTC_RST_HALT 1'b1

`endif

// ==== rtc_host_model.sv ====
// Behavioural host processor on the asynchronous byte-wide memory port of the clock.
// Assumes a free-running clock and a testbench that resolves the shared data wire.
`timescale 1ns/1ns

module rtc_host_model #(
  parameter int unsigned DLY = 2
) (
  // Clock.
  input wire logic clk,
  // Observed side of the bus.
  input wire logic [7:0] bus_level,
  input wire logic dev_oe,
  // Memory pins driven by the host.
  output logic [16:0] mem_addr,
  output logic mem_ce_n,
  output logic mem_we_n,
  output logic mem_oe_n,
  output logic [7:0] host_dq,
  output logic host_dq_oe
);
  // Cycles each pin phase is held; the pins cross two flops, so four is the floor.
  int unsigned hold_cyc = 4;

  // Idle bus at time zero.
  initial begin
    mem_addr = '0;
    mem_ce_n = 1'b1;
    mem_we_n = 1'b1;
    mem_oe_n = 1'b1;
    host_dq = 8'h00;
    host_dq_oe = 1'b0;
  end

  // Write cycle controlled by the write strobe; address and data outlive its rising edge.
  task automatic bus_write(input logic [16:0] a, input logic [7:0] d);
    @(posedge clk);
    #DLY;
    mem_addr = a;
    host_dq = d;
    host_dq_oe = 1'b1;
    mem_ce_n = 1'b0;
    mem_we_n = 1'b0;
    repeat (hold_cyc + 2) @(posedge clk);
    #DLY mem_we_n = 1'b1;
    repeat (hold_cyc + 2) @(posedge clk);
    #DLY;
    mem_ce_n = 1'b1;
    host_dq_oe = 1'b0;
    repeat (hold_cyc) @(posedge clk);
  endtask : bus_write

  // Read cycle; the request is held until the device drives or the bound runs out.
  task automatic bus_read(input logic [16:0] a, output logic [7:0] d, output logic hit);
    int unsigned n;
    hit = 1'b0;
    d = 8'h00;
    @(posedge clk);
    #DLY;
    mem_addr = a;
    mem_ce_n = 1'b0;
    mem_oe_n = 1'b0;
    for (n = 0; n < hold_cyc + 6 && !hit; n++) begin
      @(posedge clk);
      if (dev_oe === 1'b1) begin
        hit = 1'b1;
        d = bus_level;
      end
    end
    #DLY;
    mem_ce_n = 1'b1;
    mem_oe_n = 1'b1;
    repeat (hold_cyc) @(posedge clk);
  endtask : bus_read
endmodule : rtc_host_model

// ==== rtc_pkg.sv ====
// Types of the calendar clock: the single packed state record of the clock module.
// Assumes rtc_defs.svh is reachable on the include path.
`include "rtc_defs.svh"

package rtc_pkg;

  // ---------------------------------------------------------------------------
  // Whole state of the clock, registered in one process.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [16:0] a_s1;
    logic [16:0] a_s2;
    logic [7:0] d_s1;
    logic [7:0] d_s2;
    logic [7:0] d_d;
    logic [2:0] c_s1;
    logic [2:0] c_s2;
    logic [2:0] c_d;
    logic [23:0] rec_cnt;
    logic rec_done;
    logic [7:0] ctrl;
    logic prev_w;
    logic osc_halt;
    logic [24:0] start_cnt;
    logic [24:0] acc;
    logic [15:0] sub;
    logic [5:0] cyc_min;
    logic [`RTC_NUM_TIME-1:0][7:0] cnt;
    logic [`RTC_NUM_TIME-1:0][7:0] vis;
    logic [7:0] dout;
    logic doe;
  } rtc_state_t;

endpackage : rtc_pkg
